// file: rtl/swp_pkg.sv
// shared constants for the switch port control and statistics block
package swp_pkg;
  localparam int NPORT = 6;
  localparam int NCNT  = 9;
  localparam int AW    = 12;

  // counter slots inside one port's counter window
  localparam int CNT_TX_GOOD  = 0;
  localparam int CNT_TX_BAD   = 1;
  localparam int CNT_RX_GOOD  = 2;
  localparam int CNT_RX_BAD   = 3;
  localparam int CNT_TX_ABORT = 4;
  localparam int CNT_COLL     = 5;
  localparam int CNT_DROP     = 6;
  localparam int CNT_RX_BCAST = 7;
  localparam int CNT_RX_MCAST = 8;

  // byte offsets
  localparam logic [11:0] CFG_BASE   = 12'h000;
  localparam logic [11:0] CTRL_OFF   = 12'h020;
  localparam logic [11:0] APPLY_STAT = 12'h024;
  localparam logic [11:0] STAT_BASE  = 12'h040;
  localparam logic [11:0] CNT_BASE   = 12'h200;

  // port configuration fields
  localparam int CFG_EN    = 0;
  localparam int CFG_AUTO  = 1;
  localparam int CFG_SPD   = 2;
  localparam int CFG_FULL  = 4;
  localparam int CFG_FC    = 5;
  localparam int CFG_SEC   = 6;
  localparam int CFG_AGG   = 7;
  localparam int CFG_W     = 8;
  localparam logic [7:0] CFG_RST = 8'h13;

  // control fields, write one to act
  localparam int CTRL_APPLY = 0;
  localparam int CTRL_CLEAR = 1;

  // port status fields
  localparam int ST_LINK  = 0;
  localparam int ST_MEDIA = 1;
  localparam int ST_SPD   = 2;
  localparam int ST_FULL  = 4;
  localparam int ST_EN    = 5;
  localparam int ST_AGG   = 6;

  localparam logic [1:0] SPD_10M  = 2'h0;
  localparam logic [1:0] SPD_100M = 2'h1;
  localparam logic [1:0] SPD_1G   = 2'h2;

  localparam logic MEDIA_COPPER_100 = 1'b0;
  localparam logic MEDIA_GIG_COMBO  = 1'b1;

  localparam int MAX_AGG = 4;
  localparam logic [15:0] PAUSE_TIME_DEF = 16'hFFFF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: rtl/swp_stat_cnt.sv
// one clearable statistics counter
`timescale 1ns/1ps
module swp_stat_cnt #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // control
  input  wire logic         inc,
  input  wire logic         clr,
  // value
  output logic [W-1:0]      value
);
  logic [W-1:0] value_q;

  // an event in the clear cycle is kept, so it reads one afterwards
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_q <= '0;
    end else if (clr) begin
      value_q <= W'(inc);
    end else if (inc) begin
      value_q <= value_q + W'(1);
    end
  end

  assign value = value_q;
endmodule // swp_stat_cnt

// file: rtl/swp_port_ctrl.sv
// per-port control, link reporting and statistics with an axi4-lite register slave
// Notes on behaviour
// RL1 - disabled port neither sends nor receives
// RL2 - each port reports link up or down
// RL3 - each port reports its media type
// RL4 - count good transmitted packets
// RL5 - count bad transmitted packets
// RL6 - count good received packets
// RL7 - count bad received packets
// RL8 - count aborted transmissions
// RL9 - count collision packets
// RL10 - count dropped packets
// RL11 - count received broadcast packets
// RL12 - count received multicast packets
// RL13 - one clear zeroes every counter; a counter with an event in the clear cycle reads one
// RL14 - auto mode takes negotiated speed, duplex
// RL15 - forced uses settings; auto makes them read-only
// RL16 - overrun with flow control sends pause
// RL17 - overrun without flow control drops packets
// RL18 - security blocks unknown source addresses
// RL19 - settings act only on apply
// RL20 - at most four ports aggregated
// RL21 - aggregated ports must run full duplex
// RL22 - counters start at zero after reset
`timescale 1ns/1ps
module swp_port_ctrl #(
  parameter int                       NPORT      = swp_pkg::NPORT,
  parameter int                       CNT_W      = 32,
  parameter logic [NPORT-1:0]         GIG_MEDIA  = 6'h30,
  parameter logic [15:0]              PAUSE_TIME = swp_pkg::PAUSE_TIME_DEF
) (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite write
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // per-port packet events from the mac datapath, one-cycle pulses
  input  wire logic [NPORT-1:0]       tx_good_ev,
  input  wire logic [NPORT-1:0]       tx_bad_ev,
  input  wire logic [NPORT-1:0]       rx_good_ev,
  input  wire logic [NPORT-1:0]       rx_bad_ev,
  input  wire logic [NPORT-1:0]       tx_abort_ev,
  input  wire logic [NPORT-1:0]       collision_ev,
  input  wire logic [NPORT-1:0]       drop_ev,
  input  wire logic [NPORT-1:0]       rx_bcast_ev,
  input  wire logic [NPORT-1:0]       rx_mcast_ev,
  // receive admission from the mac datapath
  input  wire logic [NPORT-1:0]       rx_sof,
  input  wire logic [NPORT-1:0]       rx_sa_known,
  input  wire logic [NPORT-1:0]       rx_overrun,
  // phy pins
  input  wire logic [NPORT-1:0]       phy_link_up,
  input  wire logic [2*NPORT-1:0]     phy_an_speed,
  input  wire logic [NPORT-1:0]       phy_an_full,
  output logic [NPORT-1:0]            phy_an_enable,
  output logic [2*NPORT-1:0]          phy_force_speed,
  output logic [NPORT-1:0]            phy_force_full,
  // port control to the datapath
  output logic [NPORT-1:0]            port_tx_en,
  output logic [NPORT-1:0]            port_rx_en,
  output logic [NPORT-1:0]            pause_req,
  output logic [15:0]                 pause_time,
  output logic [NPORT-1:0]            rx_drop,
  output logic [NPORT-1:0]            rx_block,
  output logic [NPORT-1:0]            agg_member_active
);
  localparam int NCNT = swp_pkg::NCNT;

  // ---------------- pin synchronisers
  logic [NPORT-1:0]   link_s1_q, link_q;
  logic [2*NPORT-1:0] spd_s1_q, an_spd_q;
  logic [NPORT-1:0]   full_s1_q, an_full_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_s1_q <= '0;
      link_q    <= '0;
      spd_s1_q  <= '0;
      an_spd_q  <= '0;
      full_s1_q <= '0;
      an_full_q <= '0;
    end else begin
      link_s1_q <= phy_link_up;
      link_q    <= link_s1_q;
      spd_s1_q  <= phy_an_speed;
      an_spd_q  <= spd_s1_q;
      full_s1_q <= phy_an_full;
      an_full_q <= full_s1_q;
    end
  end

  // ---------------- axi4-lite write channel
  logic        awready_q, wready_q, bvalid_q, aw_have_q, w_have_q;
  logic [11:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q;
  logic        wr_do;

  assign wr_do = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      waddr_q   <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (awready_q && s_axi_awvalid) begin
        awready_q <= 1'b0;
        aw_have_q <= 1'b1;
        waddr_q   <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_have_q <= 1'b0;
      end else if (!aw_have_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (wready_q && s_axi_wvalid) begin
        wready_q <= 1'b0;
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_do) begin
        w_have_q <= 1'b0;
      end else if (!w_have_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
    end
  end

  // write decode
  logic       wr_cfg, wr_ctrl, wr_ok;
  logic [2:0] widx;
  assign widx    = waddr_q[4:2];
  assign wr_cfg  = (waddr_q[11:5] == swp_pkg::CFG_BASE[11:5]) && (int'(widx) < NPORT);
  assign wr_ctrl = (waddr_q[11:2] == swp_pkg::CTRL_OFF[11:2]);
  assign wr_ok   = wr_cfg || wr_ctrl || (waddr_q[11:2] == swp_pkg::APPLY_STAT[11:2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= swp_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? swp_pkg::RESP_OKAY : swp_pkg::RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  logic apply_p, clear_p;
  assign apply_p = wr_do && wr_ctrl && wstrb_q[0] && wdata_q[swp_pkg::CTRL_APPLY];
  // RL13 global clear pulse
  assign clear_p = wr_do && wr_ctrl && wstrb_q[0] && wdata_q[swp_pkg::CTRL_CLEAR];

  // ---------------- staged and active configuration
  logic [swp_pkg::CFG_W-1:0] shadow_q [NPORT];
  logic [swp_pkg::CFG_W-1:0] act_q    [NPORT];
  logic                      apply_err_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < NPORT; p++) begin
        shadow_q[p] <= swp_pkg::CFG_RST;
      end
    end else if (wr_do && wr_cfg && wstrb_q[0]) begin
      shadow_q[widx] <= wdata_q[swp_pkg::CFG_W-1:0];
      // RL15 speed, duplex locked in auto
      if (wdata_q[swp_pkg::CFG_AUTO]) begin
        shadow_q[widx][swp_pkg::CFG_SPD +: 2] <= shadow_q[widx][swp_pkg::CFG_SPD +: 2];
        shadow_q[widx][swp_pkg::CFG_FULL]     <= shadow_q[widx][swp_pkg::CFG_FULL];
      end
    end
  end

  // aggregation check on the staged set
  logic       agg_ok;
  logic [3:0] agg_cnt;
  always_comb begin
    agg_cnt = '0;
    agg_ok  = 1'b1;
    for (int p = 0; p < NPORT; p++) begin
      if (shadow_q[p][swp_pkg::CFG_AGG]) begin
        agg_cnt = agg_cnt + 4'h1;
        // RL21 members need full duplex
        if (shadow_q[p][swp_pkg::CFG_AUTO] ? !an_full_q[p] : !shadow_q[p][swp_pkg::CFG_FULL]) begin
          agg_ok = 1'b0;
        end
      end
    end
    // RL20 four members at most
    if (int'(agg_cnt) > swp_pkg::MAX_AGG) begin
      agg_ok = 1'b0;
    end
  end

  // a rejected apply leaves the running setup untouched as a whole
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      apply_err_q <= 1'b0;
      for (int p = 0; p < NPORT; p++) begin
        act_q[p] <= swp_pkg::CFG_RST;
      end
    end else if (apply_p) begin
      apply_err_q <= !agg_ok;
      // RL19 copy on apply only
      if (agg_ok) begin
        for (int p = 0; p < NPORT; p++) begin
          act_q[p] <= shadow_q[p];
        end
      end
    end
  end

  // ---------------- per-port datapath control
  logic [1:0]       eff_spd  [NPORT];
  logic [NPORT-1:0] eff_full;
  logic [NPORT-1:0] en, fc, sec, agg;
  logic [NPORT-1:0] ovr_prev_q, own_drop, sec_drop;

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      en[p]  = act_q[p][swp_pkg::CFG_EN];
      fc[p]  = act_q[p][swp_pkg::CFG_FC];
      sec[p] = act_q[p][swp_pkg::CFG_SEC];
      agg[p] = act_q[p][swp_pkg::CFG_AGG];
      // RL14 negotiated values in auto
      if (act_q[p][swp_pkg::CFG_AUTO]) begin
        eff_spd[p]  = an_spd_q[2*p +: 2];
        eff_full[p] = an_full_q[p];
      end else begin
        eff_spd[p]  = act_q[p][swp_pkg::CFG_SPD +: 2];
        eff_full[p] = act_q[p][swp_pkg::CFG_FULL];
      end
      // RL17 drop on overrun
      own_drop[p] = en[p] && !fc[p] && rx_overrun[p] && rx_sof[p];
      // RL18 unknown source blocked
      sec_drop[p] = en[p] && sec[p] && rx_sof[p] && !rx_sa_known[p];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_tx_en        <= '0;
      port_rx_en        <= '0;
      phy_an_enable     <= '0;
      phy_force_speed   <= '0;
      phy_force_full    <= '0;
      pause_req         <= '0;
      pause_time        <= '0;
      rx_drop           <= '0;
      rx_block          <= '0;
      agg_member_active <= '0;
      ovr_prev_q        <= '0;
    end else begin
      // RL1 gate both directions
      port_tx_en    <= en;
      port_rx_en    <= en;
      pause_time    <= PAUSE_TIME;
      ovr_prev_q    <= rx_overrun;
      rx_drop       <= own_drop;
      rx_block      <= sec_drop;
      for (int p = 0; p < NPORT; p++) begin
        phy_an_enable[p]         <= act_q[p][swp_pkg::CFG_AUTO];
        // RL15 forced values to phy
        phy_force_speed[2*p +: 2] <= act_q[p][swp_pkg::CFG_SPD +: 2];
        phy_force_full[p]        <= act_q[p][swp_pkg::CFG_FULL];
        // RL21 half duplex drops out of the group
        agg_member_active[p]     <= en[p] && agg[p] && link_q[p] && eff_full[p];
      end
      // RL16 one pause per overrun onset
      pause_req <= en & fc & rx_overrun & ~ovr_prev_q;
    end
  end

  // ---------------- statistics counters
  logic [CNT_W-1:0] cnt_val [NPORT*NCNT];
  logic [NCNT-1:0]  cnt_inc [NPORT];

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      cnt_inc[p] = '0;
      if (en[p]) begin
        // RL4 good tx
        cnt_inc[p][swp_pkg::CNT_TX_GOOD]  = tx_good_ev[p];
        // RL5 bad tx
        cnt_inc[p][swp_pkg::CNT_TX_BAD]   = tx_bad_ev[p];
        // RL6 good rx
        cnt_inc[p][swp_pkg::CNT_RX_GOOD]  = rx_good_ev[p] && !sec_drop[p];
        // RL7 bad rx
        cnt_inc[p][swp_pkg::CNT_RX_BAD]   = rx_bad_ev[p];
        // RL8 aborted tx
        cnt_inc[p][swp_pkg::CNT_TX_ABORT] = tx_abort_ev[p];
        // RL9 collisions
        cnt_inc[p][swp_pkg::CNT_COLL]     = collision_ev[p];
        // RL10 all drop causes
        cnt_inc[p][swp_pkg::CNT_DROP]     = drop_ev[p] || own_drop[p] || sec_drop[p];
        // RL11 broadcast rx
        cnt_inc[p][swp_pkg::CNT_RX_BCAST] = rx_bcast_ev[p] && !sec_drop[p];
        // RL12 multicast rx
        cnt_inc[p][swp_pkg::CNT_RX_MCAST] = rx_mcast_ev[p] && !sec_drop[p];
      end
    end
  end

  // RL22 counters reset to zero
  for (genvar gp = 0; gp < NPORT; gp++) begin : g_port
    for (genvar gk = 0; gk < NCNT; gk++) begin : g_cnt
      swp_stat_cnt #(
        .W       (CNT_W)
      ) u_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .inc     (cnt_inc[gp][gk]),
        .clr     (clear_p),
        .value   (cnt_val[gp*NCNT+gk])
      );
    end
  end

  // ---------------- axi4-lite read channel
  logic        arready_q, rvalid_q;
  logic [31:0] rdata_q, rd_word;
  logic [1:0]  rresp_q, rd_resp;
  logic [11:0] ra;
  logic [2:0]  ridx;

  assign ra   = s_axi_araddr;
  assign ridx = ra[4:2];

  always_comb begin
    rd_word = '0;
    rd_resp = swp_pkg::RESP_OKAY;
    if ((ra[11:5] == swp_pkg::CFG_BASE[11:5]) && (int'(ridx) < NPORT)) begin
      rd_word[swp_pkg::CFG_W-1:0] = shadow_q[ridx];
    end else if (ra[11:2] == swp_pkg::CTRL_OFF[11:2]) begin
      rd_word = '0;
    end else if (ra[11:2] == swp_pkg::APPLY_STAT[11:2]) begin
      rd_word[0]   = apply_err_q;
      rd_word[7:4] = agg_cnt;
    end else if ((ra[11:5] == swp_pkg::STAT_BASE[11:5]) && (int'(ridx) < NPORT)) begin
      // RL2 link state
      rd_word[swp_pkg::ST_LINK]     = link_q[ridx];
      // RL3 media type
      rd_word[swp_pkg::ST_MEDIA]    = GIG_MEDIA[ridx] ? swp_pkg::MEDIA_GIG_COMBO : swp_pkg::MEDIA_COPPER_100;
      rd_word[swp_pkg::ST_SPD +: 2] = eff_spd[ridx];
      rd_word[swp_pkg::ST_FULL]     = eff_full[ridx];
      rd_word[swp_pkg::ST_EN]       = en[ridx];
      rd_word[swp_pkg::ST_AGG]      = agg_member_active[ridx];
    end else if ((ra[11:10] == swp_pkg::CNT_BASE[11:10]) && ra[9] && (int'(ra[8:6]) < NPORT)
                 && (int'(ra[5:2]) < NCNT)) begin
      rd_word = 32'(cnt_val[int'(ra[8:6])*NCNT + int'(ra[5:2])]);
    end else begin
      rd_resp = swp_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= swp_pkg::RESP_OKAY;
    end else if (arready_q && s_axi_arvalid) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_resp;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
endmodule // swp_port_ctrl

// file: bench/swp_port_ctrl_props.sv
// concurrent checks on the port control block ports
`timescale 1ns/1ps
module swp_port_ctrl_props #(
  parameter int          NPORT      = 6,
  parameter logic [15:0] PAUSE_TIME = 16'hFFFF
) (
  // clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // register bus
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic [1:0]       s_axi_bresp,
  // datapath
  input wire logic [NPORT-1:0] rx_sof,
  input wire logic [NPORT-1:0] rx_sa_known,
  input wire logic [NPORT-1:0] rx_overrun,
  input wire logic [NPORT-1:0] rx_drop,
  input wire logic [NPORT-1:0] rx_block,
  input wire logic [NPORT-1:0] pause_req,
  input wire logic [15:0]      pause_time,
  input wire logic [NPORT-1:0] port_tx_en,
  input wire logic [NPORT-1:0] port_rx_en,
  input wire logic [NPORT-1:0] agg_member_active
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_drop_cause: assert property ((rx_drop & ~$past(rx_sof & rx_overrun)) == '0)
    else $error("drop without overrun frame");
  a_block_cause: assert property ((rx_block & ~$past(rx_sof & ~rx_sa_known)) == '0)
    else $error("block without unknown source");
  a_pause_cause: assert property ((pause_req & ~$past(rx_overrun)) == '0)
    else $error("pause without overrun");
  a_pause_pulse: assert property ((pause_req & $past(pause_req)) == '0)
    else $error("pause longer than a pulse");
  a_pause_time: assert property ($past(aresetn) |-> pause_time == PAUSE_TIME)
    else $error("pause time wrong");
  a_en_pair: assert property (port_tx_en == port_rx_en)
    else $error("tx and rx enable differ");
  a_agg_enabled: assert property ((agg_member_active & ~port_tx_en) == '0)
    else $error("aggregate member on disabled port");

  c_drop: cover property (|rx_drop);
  c_pause: cover property (|pause_req);
  c_agg: cover property (|agg_member_active);
endmodule // swp_port_ctrl_props

// file: bench/swp_link_partner.sv
// link partner model driving the phy pins of all six ports
`timescale 1ns/1ps
module swp_link_partner #(
  parameter logic [5:0] GIG = 6'h30
) (
  // control from the bench
  input  wire logic        aclk,
  input  wire logic [5:0]  up_cmd,
  // phy pins
  input  wire logic [5:0]  phy_an_enable,
  output logic      [5:0]  phy_link_up = '0,
  output logic      [11:0] phy_an_speed = '0,
  output logic      [5:0]  phy_an_full = '0
);
  // results toggle while not negotiating, so stale values are never trusted
  always @(posedge aclk) begin
    for (int p = 0; p < 6; p++) begin
      phy_link_up[p] <= up_cmd[p];
      if (phy_an_enable[p])
        phy_an_speed[2*p+:2] <= GIG[p] ? swp_pkg::SPD_1G : swp_pkg::SPD_100M;
      else
        phy_an_speed[2*p+:2] <= ~phy_an_speed[2*p+:2];
      phy_an_full[p] <= phy_an_enable[p] ? 1'b1 : ~phy_an_full[p];
    end
  end
endmodule // swp_link_partner

// file: bench/swp_port_ctrl_bench.sv
// self-checking bench for the port control block
`timescale 1ns/1ps
module swp_port_ctrl_bench;
  logic        aclk, aresetn, seen_clr;
  logic [11:0] s_axi_awaddr, s_axi_araddr, phy_an_speed, phy_force_speed;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0]  ev [9];
  logic [5:0]  rx_sof, rx_sa_known, rx_overrun, phy_link_up, phy_an_full, phy_an_enable;
  logic [5:0]  phy_force_full, port_tx_en, port_rx_en, pause_req, rx_drop, rx_block;
  logic [5:0]  agg_member_active, up_cmd, drop_seen, blk_seen, pause_seen;
  logic [15:0] pause_time;
  int          error_cnt, checks_done;

  swp_port_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .tx_good_ev(ev[0]), .tx_bad_ev(ev[1]), .rx_good_ev(ev[2]), .rx_bad_ev(ev[3]),
    .tx_abort_ev(ev[4]), .collision_ev(ev[5]), .drop_ev(ev[6]), .rx_bcast_ev(ev[7]),
    .rx_mcast_ev(ev[8]), .rx_sof, .rx_sa_known, .rx_overrun, .phy_link_up, .phy_an_speed,
    .phy_an_full, .phy_an_enable, .phy_force_speed, .phy_force_full, .port_tx_en, .port_rx_en,
    .pause_req, .pause_time, .rx_drop, .rx_block, .agg_member_active);
  swp_link_partner lp_u (.aclk, .up_cmd, .phy_an_enable, .phy_link_up, .phy_an_speed, .phy_an_full);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // output pulses are caught here so checks do not depend on exact latency
  always @(posedge aclk) begin
    drop_seen  <= seen_clr ? '0 : drop_seen | rx_drop;
    blk_seen   <= seen_clr ? '0 : blk_seen | rx_block;
    pause_seen <= seen_clr ? '0 : pause_seen | pause_req;
  end

  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e = 2'h0);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  rr;
    rd(a, v, rr);
    chk($sformatf("reg %h", a), e, v);
  endtask

  function automatic logic [11:0] ca(input int p, k);
    return swp_pkg::CNT_BASE + 12'(p * 64 + k * 4);
  endfunction

  task automatic pulse(input int k, p, n);
    repeat (n) begin
      @(posedge aclk);
      ev[k][p] <= 1'b1;
      @(posedge aclk);
      ev[k][p] <= 1'b0;
    end
  endtask

  task automatic sof(input int p, input logic known);
    @(posedge aclk);
    rx_sa_known[p] <= known;
    rx_sof[p]      <= 1'b1;
    @(posedge aclk);
    rx_sof[p] <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic clr_seen;
    @(posedge aclk);
    seen_clr <= 1'b1;
    @(posedge aclk);
    seen_clr <= 1'b0;
  endtask

  task automatic finish_test;
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    finish_test;
  end

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    foreach (ev[k]) ev[k] = '0;
    rx_sof = '0;
    rx_sa_known = 6'h3F;
    rx_overrun = '0;
    up_cmd = 6'h3F;
    seen_clr = 1'b1;
    error_cnt = 0;
    checks_done = 0;
    repeat (2) @(posedge aclk);
    aresetn  <= 1'b1;
    seen_clr <= 1'b0;
    repeat (8) @(posedge aclk);
    rdc(swp_pkg::CFG_BASE, 32'h13);
    for (int k = 0; k < 9; k++) rdc(ca(0, k), 32'h0);
    rdc(swp_pkg::STAT_BASE, 32'h35);
    rdc(swp_pkg::STAT_BASE + 12'h014, 32'h3B);
    up_cmd[2] <= 1'b0;
    repeat (6) @(posedge aclk);
    rdc(swp_pkg::STAT_BASE + 12'h008, 32'h34);
    rd(12'h100, d, r);
    chk("rresp", 32'(swp_pkg::RESP_SLVERR), {30'h0, r});
    chk("rdata", 32'h0, d);
    wr(12'h100, 32'h1, swp_pkg::RESP_SLVERR);
    for (int k = 0; k < 9; k++) begin
      pulse(k, 1, k + 1);
      rdc(ca(1, k), 32'(k + 1));
    end
    wr(swp_pkg::CTRL_OFF, 32'h2);
    for (int k = 0; k < 9; k++) rdc(ca(1, k), 32'h0);
    wr(swp_pkg::CFG_BASE + 12'h008, 32'h12);
    pulse(0, 2, 1);
    rdc(ca(2, 0), 32'h1);
    wr(swp_pkg::CTRL_OFF, 32'h1);
    pulse(0, 2, 1);
    rdc(ca(2, 0), 32'h1);
    chk("rx_en", 32'h0, 32'(port_rx_en[2]));
    chk("tx_en", 32'h0, 32'(port_tx_en[2]));
    wr(swp_pkg::CFG_BASE + 12'h00C, 32'h09);
    wr(swp_pkg::CTRL_OFF, 32'h1);
    // phy controls follow the active set one edge after the apply lands
    repeat (2) @(posedge aclk);
    chk("force", 32'h2, 32'(phy_force_speed[7:6]));
    chk("auto", 32'h0, 32'(phy_an_enable[3]));
    chk("force_full", 32'h0, 32'(phy_force_full[3]));
    wr(swp_pkg::CFG_BASE + 12'h010, 32'h1B);
    rdc(swp_pkg::CFG_BASE + 12'h010, 32'h13);
    rx_overrun[0] <= 1'b1;
    sof(0, 1'b1);
    chk("drop", 32'h1, 32'(drop_seen[0]));
    wr(swp_pkg::CFG_BASE, 32'h33);
    wr(swp_pkg::CTRL_OFF, 32'h1);
    rx_overrun[0] <= 1'b0;
    clr_seen;
    rx_overrun[0] <= 1'b1;
    sof(0, 1'b1);
    chk("pause", 32'h1, 32'(pause_seen[0]));
    chk("drop", 32'h0, 32'(drop_seen[0]));
    wr(swp_pkg::CFG_BASE + 12'h004, 32'h53);
    wr(swp_pkg::CTRL_OFF, 32'h1);
    clr_seen;
    sof(1, 1'b0);
    chk("block", 32'h1, 32'(blk_seen[1]));
    clr_seen;
    sof(1, 1'b1);
    chk("block", 32'h0, 32'(blk_seen[1]));
    for (int p = 0; p < 6; p++) if (p != 2 && p != 3) wr(swp_pkg::CFG_BASE + 12'(4 * p), 32'h93);
    wr(swp_pkg::CFG_BASE + 12'h00C, 32'h89);
    wr(swp_pkg::CTRL_OFF, 32'h1);
    rdc(swp_pkg::APPLY_STAT, 32'h51);
    wr(swp_pkg::CFG_BASE + 12'h014, 32'h13);
    wr(swp_pkg::CTRL_OFF, 32'h1);
    rdc(swp_pkg::APPLY_STAT, 32'h41);
    wr(swp_pkg::CFG_BASE + 12'h00C, 32'h91);
    wr(swp_pkg::CTRL_OFF, 32'h1);
    rdc(swp_pkg::APPLY_STAT, 32'h40);
    chk("agg", 32'h1B, 32'(agg_member_active));
    finish_test;
  end
endmodule // swp_port_ctrl_bench

bind swp_port_ctrl swp_port_ctrl_props #(.NPORT(NPORT), .PAUSE_TIME(PAUSE_TIME)) props_u (.aclk, .aresetn,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .rx_sof, .rx_sa_known, .rx_overrun, .rx_drop, .rx_block, .pause_req, .pause_time,
  .port_tx_en, .port_rx_en, .agg_member_active);
